// *** design/ccs_pkg.sv ***
// Purpose: Shared constants and types for the charger control sequencer
// Assumes: 200 MHz clock; analog comparators arrive as pin levels
// Notes:   Times are kept in their printed unit, counts derived from them
package ccs_pkg;

  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned ALERT_PULSE_US   = 128;
  localparam int unsigned ALERT_PULSE_CYC  = ALERT_PULSE_US * CLK_MHZ;
  localparam int unsigned OVP_DGL_US       = 32;
  localparam int unsigned OVP_DGL_CYC      = OVP_DGL_US * CLK_MHZ;
  localparam int unsigned UVLO_DGL_US      = 32;
  localparam int unsigned UVLO_DGL_CYC     = UVLO_DGL_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 16;

  // Input voltage floor: code 0 = 4.2 V, step 100 mV, max code 7 = 4.9 V
  localparam logic [2:0]  FLOOR_CODE_MAX   = 3'h7;
  localparam logic [2:0]  FLOOR_CODE_RST   = 3'h0;
  // Input current limit: code 0 = 50 mA, step 50 mA, code 7 = 400 mA
  localparam logic [2:0]  INPUT_CURRENT_LIMIT_PIN_CODE_RST    = 3'h0;
  // Termination current code: 500 uA to 37 mA, code units of 500 uA
  localparam logic [6:0]  TERM_CODE_MIN    = 7'h01;
  localparam logic [6:0]  TERM_CODE_MAX    = 7'h4a;
  localparam logic [6:0]  TERM_CODE_RST    = 7'h14;
  // External termination: 0..3 = 5, 10, 15, 20 percent of charge current
  localparam logic [1:0]  TERM_PCT_RST     = 2'h1;

  typedef enum logic [2:0] {
    CCS_IDLE, CCS_CC, CCS_CV, CCS_DONE, CCS_FAULT
  } ccs_chg_e;

  // Analog comparator levels, all raw from pins
  typedef struct packed {
    logic vin_valid;
    logic vin_ovp;
    logic vin_uvlo;
    logic vin_at_floor;
    logic cell_at_reg;
    logic cur_below_taper;
    logic cell_above_rechg;
    logic in_cur_over_lim;
    logic mid_below_entry;
    logic mid_above_exit;
  } ccs_sense_s;

  // Host-side configuration
  typedef struct packed {
    logic       floor_en;
    logic [2:0] floor_code;
    logic       dbl_timer;
    logic       term_en;
    logic       chg_disable;
    logic [6:0] term_code;
    logic [2:0] input_current_limit_pin_code;
  } ccs_cfg_s;

  // Setting pins, straps: presence and decoded value
  typedef struct packed {
    logic       input_current_limit_pin_ext;
    logic [2:0] input_current_limit_pin_ext_code;
    logic       term_ext;
    logic [1:0] term_ext_pct;
    logic       charge_current_pin_ext;
  } ccs_strap_s;

  typedef struct packed {
    logic       floor_stat;
    logic       ovp_fault;
    logic       uvlo_fault;
    logic [2:0] progress;
    logic       host_mode;
    logic       supplement;
  } ccs_stat_s;

endpackage

// *** design/ccs_sequencer.sv ***
// Behaviour
// - Floor function can be switched off by configuration.
// - Floor loop active sets status bit and inhibits termination.
// - Double timer option extends safety timer while floor loop active.
// - Deglitched overvoltage: fault, discharge path on, one alert pulse.
// - Overvoltage removed: clear progress field, resume normal operation.
// - Overvoltage fault bits stay until read after condition ends.
// - Deglitched undervoltage: fault, one alert pulse, progress and bits.
// - Undervoltage fault bits stay until read after condition ends.
// - Valid input and disable bit 1: discharge path off, no charging.
// - Writing 0 to disable bit starts charge; pin also controls charge.
// - Constant current until regulation voltage, then constant voltage.
// - Termination in CV when current tapers and cell above recharge.
// - Termination inhibited when any loop other than CV dominates.
// - Reduce input current when charge plus load exceed input limit.
// - Supplement mode enters and leaves on mid supply margins.
// - Default mode on valid input arrival or reset bit write.
// - Host write without a same-cycle reset bit or input arrival leaves default mode for host mode.
// - Default mode uses strap values or register defaults when grounded.
// - Register termination current from 500 uA to 37 mA.
// - External termination 5, 10, 15 or 20 percent of charge current.
// - Pre-charge current equals termination current.
// - Register input current limit 50 to 400 mA in 50 mA steps.
// - Host mode ignores external input limit; grounded pin uses register.
//
// Purpose: Charge control sequencer with fault detection and mode control
// Assumes: Comparator levels and straps arrive asynchronously from pins
// Notes:   Host writes arrive as one-cycle pulses from an I2C front end
`timescale 1ns/100ps

module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter int unsigned ALERT_CYC = ALERT_PULSE_CYC,
  parameter int unsigned OVP_CYC   = OVP_DGL_CYC,
  parameter int unsigned UVLO_CYC  = UVLO_DGL_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire ccs_sense_s sense_i,
  input  wire ccs_strap_s strap_i,
  input  wire logic       charge_disable_pin_i,
  input  wire ccs_cfg_s   cfg_wdata_i,
  input  wire logic       host_write_i,
  input  wire logic       host_reset_bit_i,
  input  wire logic       fault_read_i,
  output logic            host_alert_pulse_o,
  output logic            discharge_path_on_o,
  output logic            charge_path_on_o,
  output logic            cc_loop_o,
  output logic            cv_loop_o,
  output logic            in_cur_reduce_o,
  output logic            timer_half_rate_o,
  output logic [2:0]      input_current_limit_pin_code_o,
  output logic [6:0]      term_code_o,
  output logic [6:0]      prechg_code_o,
  output logic [1:0]      term_pct_o,
  output logic            term_use_pct_o,
  output logic [2:0]      floor_code_o,
  output ccs_stat_s       stat_o
);

  // Pin synchronisers
  ccs_sense_s sense_m_q;
  ccs_sense_s sense_q;
  logic       cdpin_m_q;
  logic       cdpin_q;
  ccs_strap_s strap_m_q;
  ccs_strap_s strap_q;

  always_ff @(posedge clk_i) begin
    sense_m_q <= sense_i;
    sense_q   <= sense_m_q;
  end

  always_ff @(posedge clk_i) begin
    cdpin_m_q <= charge_disable_pin_i;
    cdpin_q   <= cdpin_m_q;
  end

  always_ff @(posedge clk_i) begin
    strap_m_q <= strap_i;
    strap_q   <= strap_m_q;
  end

  // Deglitch counters, one per fault source
  logic [1:0] dgl_in;
  logic [1:0] dgl_hit;
  logic [CNT_W-1:0] dgl_lim [2];
  assign dgl_in[0]  = sense_q.vin_ovp;
  assign dgl_in[1]  = sense_q.vin_uvlo;
  assign dgl_lim[0] = CNT_W'(OVP_CYC);
  assign dgl_lim[1] = CNT_W'(UVLO_CYC);

  for (genvar g = 0; g < 2; g++) begin : g_dgl
    logic [CNT_W-1:0] cnt_q;
    logic             hit_q;
    always_ff @(posedge clk_i) begin
      if (sys_rst_i || !dgl_in[g]) begin
        cnt_q <= '0;
        hit_q <= 1'b0;
      end else if (cnt_q >= dgl_lim[g] - CNT_W'(1)) begin
        hit_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
    assign dgl_hit[g] = hit_q;
  end

  logic ovp_hit_q;
  logic uvlo_hit_q;
  logic vin_valid_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ovp_hit_q   <= 1'b0;
      uvlo_hit_q  <= 1'b0;
      vin_valid_q <= 1'b0;
    end else begin
      ovp_hit_q   <= dgl_hit[0];
      uvlo_hit_q  <= dgl_hit[1];
      vin_valid_q <= sense_q.vin_valid;
    end
  end

  // Deglitch edges and input qualification
  wire ovp_rise  = dgl_hit[0] && !ovp_hit_q;
  wire ovp_fall  = !dgl_hit[0] && ovp_hit_q;
  wire uvlo_rise = dgl_hit[1] && !uvlo_hit_q;
  wire vin_arr   = sense_q.vin_valid && !vin_valid_q;
  wire in_fault  = dgl_hit[0] || dgl_hit[1];
  wire input_ok  = sense_q.vin_valid && !in_fault;

  // Sticky fault bits: set wins over a read clear
  logic ovp_flag_q;
  logic uvlo_flag_q;
  wire  ovp_clr  = fault_read_i && !dgl_hit[0];
  wire  uvlo_clr = fault_read_i && !dgl_hit[1];
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ovp_flag_q  <= 1'b0;
      uvlo_flag_q <= 1'b0;
    end else begin
      ovp_flag_q  <= ovp_rise  || (ovp_flag_q  && !ovp_clr);
      uvlo_flag_q <= uvlo_rise || (uvlo_flag_q && !uvlo_clr);
    end
  end

  // Alert pulse, one per fault entry
  logic [CNT_W-1:0] alert_cnt_q;
  logic             alert_q;
  wire              alert_start = ovp_rise || uvlo_rise;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alert_cnt_q <= '0;
      alert_q     <= 1'b0;
    end else if (alert_start) begin
      alert_cnt_q <= CNT_W'(ALERT_CYC - 1);
      alert_q     <= 1'b1;
    end else if (alert_cnt_q != '0) begin
      alert_cnt_q <= alert_cnt_q - CNT_W'(1);
    end else begin
      alert_q     <= 1'b0;
    end
  end

  // Write data with out-of-range codes clamped
  wire      term_lo = cfg_wdata_i.term_code < TERM_CODE_MIN;
  wire      term_hi = cfg_wdata_i.term_code > TERM_CODE_MAX;
  ccs_cfg_s cfg_wr;
  always_comb begin
    cfg_wr = cfg_wdata_i;
    if (cfg_wdata_i.floor_code > FLOOR_CODE_MAX) begin
      cfg_wr.floor_code = FLOOR_CODE_MAX;
    end
    if (term_lo) begin
      cfg_wr.term_code = TERM_CODE_MIN;
    end else if (term_hi) begin
      cfg_wr.term_code = TERM_CODE_MAX;
    end
  end

  // Configuration and default / host mode
  ccs_cfg_s cfg_q;
  logic     host_mode_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || host_reset_bit_i || vin_arr) begin
      cfg_q.floor_en    <= 1'b1;
      cfg_q.floor_code  <= FLOOR_CODE_RST;
      cfg_q.dbl_timer   <= 1'b0;
      cfg_q.term_en     <= 1'b1;
      cfg_q.chg_disable <= 1'b0;
      cfg_q.term_code   <= TERM_CODE_RST;
      cfg_q.input_current_limit_pin_code   <= INPUT_CURRENT_LIMIT_PIN_CODE_RST;
      host_mode_q       <= 1'b0;
    end else if (host_write_i) begin
      cfg_q       <= cfg_wr;
      host_mode_q <= 1'b1;
    end
  end

  // Setting selection
  wire       use_ext_input_current_limit_pin = strap_q.input_current_limit_pin_ext && !host_mode_q;
  wire [2:0] input_current_limit_pin_sel = use_ext_input_current_limit_pin ? strap_q.input_current_limit_pin_ext_code
                                     : cfg_q.input_current_limit_pin_code;
  wire       use_ext_term = strap_q.term_ext && !host_mode_q;

  // Loop dominance and charge state
  wire floor_act = cfg_q.floor_en && sense_q.vin_at_floor;
  wire charge_en = !cfg_q.chg_disable && !cdpin_q;
  logic supp_q;
  wire  other_loop = floor_act || sense_q.in_cur_over_lim || supp_q;
  wire  term_ok = cfg_q.term_en && !other_loop && sense_q.cur_below_taper
                  && sense_q.cell_above_rechg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      supp_q <= 1'b0;
    end else if (sense_q.mid_below_entry) begin
      supp_q <= 1'b1;
    end else if (sense_q.mid_above_exit) begin
      supp_q <= 1'b0;
    end
  end

  // Charge state; faults and disables override the step
  ccs_chg_e st_q;
  ccs_chg_e st_d;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      CCS_IDLE: if (input_ok && charge_en) begin
        st_d = CCS_CC;
      end
      CCS_CC: if (sense_q.cell_at_reg) begin
        st_d = CCS_CV;
      end
      CCS_CV: if (term_ok) begin
        st_d = CCS_DONE;
      end
      CCS_DONE: if (!sense_q.cell_above_rechg) begin
        st_d = CCS_CC;
      end
      CCS_FAULT: if (!in_fault) begin
        st_d = CCS_IDLE;
      end
    endcase
    if (in_fault) begin
      st_d = CCS_FAULT;
    end else if (st_q != CCS_FAULT && (!input_ok || !charge_en)) begin
      st_d = CCS_IDLE;
    end
  end

  // Progress code: 0 idle, 1 charging, 2 done, 4 fault
  logic [2:0] prog_d;
  logic [2:0] prog_q;
  always_comb begin
    prog_d = {1'b0, st_d == CCS_DONE, st_d == CCS_CC || st_d == CCS_CV};
    if (ovp_fall) begin
      prog_d = 3'h0;
    end else if (st_d == CCS_FAULT) begin
      prog_d = 3'h4;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q   <= CCS_IDLE;
      prog_q <= 3'h0;
    end else begin
      st_q   <= st_d;
      prog_q <= prog_d;
    end
  end

  // Alert and path outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      host_alert_pulse_o  <= 1'b0;
      discharge_path_on_o <= 1'b0;
      charge_path_on_o    <= 1'b0;
    end else begin
      host_alert_pulse_o  <= alert_q;
      // Discharge on in fault or supplement; off when input feeds load
      discharge_path_on_o <= in_fault || supp_q
                             || !sense_q.vin_valid;
      charge_path_on_o    <= st_q == CCS_CC || st_q == CCS_CV;
    end
  end

  // Loop indications
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cc_loop_o         <= 1'b0;
      cv_loop_o         <= 1'b0;
      in_cur_reduce_o   <= 1'b0;
      timer_half_rate_o <= 1'b0;
    end else begin
      cc_loop_o         <= st_q == CCS_CC;
      cv_loop_o         <= st_q == CCS_CV;
      in_cur_reduce_o   <= floor_act
                           || sense_q.in_cur_over_lim;
      timer_half_rate_o <= cfg_q.dbl_timer && floor_act;
    end
  end

  // Selected settings
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      input_current_limit_pin_code_o    <= INPUT_CURRENT_LIMIT_PIN_CODE_RST;
      term_code_o    <= TERM_CODE_RST;
      prechg_code_o  <= TERM_CODE_RST;
      term_pct_o     <= TERM_PCT_RST;
      term_use_pct_o <= 1'b0;
      floor_code_o   <= FLOOR_CODE_RST;
    end else begin
      input_current_limit_pin_code_o    <= input_current_limit_pin_sel;
      term_code_o    <= cfg_q.term_code;
      prechg_code_o  <= cfg_q.term_code;
      term_pct_o     <= strap_q.term_ext_pct;
      term_use_pct_o <= use_ext_term;
      floor_code_o   <= cfg_q.floor_code;
    end
  end

  // Status word
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stat_o <= '0;
    end else begin
      stat_o.floor_stat <= floor_act;
      stat_o.ovp_fault  <= ovp_flag_q;
      stat_o.uvlo_fault <= uvlo_flag_q;
      stat_o.progress   <= prog_q;
      stat_o.host_mode  <= host_mode_q;
      stat_o.supplement <= supp_q;
    end
  end

endmodule

// *** verification/ccs_host_model.sv ***
// Purpose: Host side model issuing write, reset-bit and fault-read pulses
// Assumes: One-cycle pulses, launched just after a rising edge
// Notes:   A gap of one idle cycle separates back to back calls
`timescale 1ns/100ps
module ccs_host_model
  import ccs_pkg::*;
(
  input  wire logic clk_i,
  output ccs_cfg_s  cfg_o,
  output logic      write_o,
  output logic      reset_bit_o,
  output logic      read_o
);
  initial begin
    cfg_o = '0;
    write_o = 1'b0;
    reset_bit_o = 1'b0;
    read_o = 1'b0;
  end
  // Kind 0 write, 1 reset bit, 2 fault read
  task automatic pulse(input int kind, input ccs_cfg_s c);
    @(posedge clk_i);
    #1;
    cfg_o = c;
    write_o = (kind == 0);
    reset_bit_o = (kind == 1);
    read_o = (kind == 2);
    @(posedge clk_i);
    #1;
    write_o = 1'b0;
    reset_bit_o = 1'b0;
    read_o = 1'b0;
  endtask
endmodule

// *** verification/ccs_seq_sva.sv ***
// Purpose: Port level assertions for the charger sequencer
// Assumes: Single clock, synchronous reset
// Notes:   Alert width allowed one cycle of slack long, two cycles short
`timescale 1ns/100ps
module ccs_seq_sva
  import ccs_pkg::*;
#(
  parameter int unsigned ALERT_CYC = ALERT_PULSE_CYC
) (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       charge_disable_pin_i,
  input wire logic       host_write_i,
  input wire logic       host_reset_bit_i,
  input wire logic       fault_read_i,
  input wire ccs_cfg_s   cfg_wdata_i,
  input wire logic       host_alert_pulse_o,
  input wire logic       discharge_path_on_o,
  input wire logic       charge_path_on_o,
  input wire logic       in_cur_reduce_o,
  input wire logic       timer_half_rate_o,
  input wire logic [2:0] input_current_limit_pin_code_o,
  input wire logic [6:0] term_code_o,
  input wire logic [6:0] prechg_code_o,
  input wire ccs_stat_s  stat_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [15:0] hi_q;
  logic [3:0]  dis_q;
  always_ff @(posedge clk_i) begin
    hi_q  <= (sys_rst_i || !host_alert_pulse_o) ? '0 : hi_q + 16'h0001;
    dis_q <= (sys_rst_i || !charge_disable_pin_i) ? '0
           : dis_q + 4'(dis_q != 4'hf);
  end
  sequence fault_rise;
    $rose(stat_o.ovp_fault) || $rose(stat_o.uvlo_fault);
  endsequence
  sequence host_take;
    host_write_i && !host_reset_bit_i;
  endsequence
  a_alert_after_fault: assert property (
    fault_rise |-> ##1 host_alert_pulse_o) else $error("alert missing");
  a_alert_width_max: assert property (
    32'(hi_q) <= ALERT_CYC + 1) else $error("alert too long");
  a_alert_width_min: assert property (
    $fell(host_alert_pulse_o) && !$past(sys_rst_i)
    |-> 32'(hi_q) + 2 >= ALERT_CYC) else $error("alert too short");
  a_ovp_discharge_on: assert property (
    $rose(stat_o.ovp_fault) |-> ##[0:2] discharge_path_on_o)
    else $error("discharge off in ovp");
  a_ovp_fault_sticky: assert property (
    $fell(stat_o.ovp_fault) |-> $past(fault_read_i) || $past(sys_rst_i)
    || $past(fault_read_i, 2) || $past(fault_read_i, 3))
    else $error("ovp bit cleared unread");
  a_uvlo_fault_sticky: assert property (
    $fell(stat_o.uvlo_fault) |-> $past(fault_read_i) || $past(sys_rst_i)
    || $past(fault_read_i, 2) || $past(fault_read_i, 3))
    else $error("uvlo bit cleared unread");
  a_host_mode_entry: assert property (
    host_take |-> ##2 stat_o.host_mode) else $error("no host mode");
  a_input_current_limit_pin_code_load: assert property (
    host_take |-> ##2 input_current_limit_pin_code_o == $past(cfg_wdata_i.input_current_limit_pin_code, 2))
    else $error("input_current_limit_pin code wrong");
  a_reset_bit_default: assert property (
    host_reset_bit_i |-> ##2 !stat_o.host_mode) else $error("still host");
  a_prechg_eq_term: assert property (
    prechg_code_o == term_code_o) else $error("prechg differs");
  a_term_code_range: assert property (
    term_code_o inside {[7'h01:7'h4a]}) else $error("term out of range");
  a_floor_reduces_in: assert property (
    stat_o.floor_stat |-> in_cur_reduce_o) else $error("no reduce");
  a_timer_only_floor: assert property (
    timer_half_rate_o |-> stat_o.floor_stat) else $error("timer slowed");
  a_loop_blocks_term: assert property (
    (stat_o.floor_stat || stat_o.supplement) && stat_o.progress != 3'h2
    |=> stat_o.progress != 3'h2) else $error("terminated in loop");
  a_pin_stops_charge: assert property (
    dis_q > 4'h6 |-> !charge_path_on_o) else $error("charging disabled");
endmodule

bind ccs_sequencer ccs_seq_sva #(.ALERT_CYC(ALERT_CYC)) i_sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .fault_read_i(fault_read_i),
  .charge_disable_pin_i(charge_disable_pin_i), .host_write_i(host_write_i),
  .host_reset_bit_i(host_reset_bit_i), .cfg_wdata_i(cfg_wdata_i),
  .host_alert_pulse_o(host_alert_pulse_o), .stat_o(stat_o),
  .discharge_path_on_o(discharge_path_on_o), .input_current_limit_pin_code_o(input_current_limit_pin_code_o),
  .charge_path_on_o(charge_path_on_o), .in_cur_reduce_o(in_cur_reduce_o),
  .timer_half_rate_o(timer_half_rate_o), .term_code_o(term_code_o),
  .prechg_code_o(prechg_code_o));

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the charger sequencer
// Assumes: Shortened alert and deglitch counts
// Notes:   Sense levels need a few cycles through the synchronisers
`timescale 1ns/100ps
module tb_top;
  import ccs_pkg::*;
  logic       clk_i, sys_rst_i, charge_disable_pin_i;
  logic       host_write_i, host_reset_bit_i, fault_read_i;
  logic       alert, dis_on, chg_on, cc_o, cv_o, red_o, tmr_o, use_pct;
  logic [2:0] input_current_limit_pin_o, floor_o;
  logic [6:0] term_o, pre_o;
  logic [1:0] pct_o;
  ccs_sense_s sense_i;
  ccs_strap_s strap_i;
  ccs_cfg_s   cfg_wdata_i, c;
  ccs_stat_s  st;
  int         fail_count, compares;
  ccs_sequencer #(.ALERT_CYC(8), .OVP_CYC(4), .UVLO_CYC(4)) i_ccs_sequencer (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sense_i(sense_i),
    .strap_i(strap_i), .charge_disable_pin_i(charge_disable_pin_i),
    .cfg_wdata_i(cfg_wdata_i), .host_write_i(host_write_i),
    .host_reset_bit_i(host_reset_bit_i), .fault_read_i(fault_read_i),
    .host_alert_pulse_o(alert), .discharge_path_on_o(dis_on),
    .charge_path_on_o(chg_on), .cc_loop_o(cc_o), .cv_loop_o(cv_o),
    .in_cur_reduce_o(red_o), .timer_half_rate_o(tmr_o),
    .input_current_limit_pin_code_o(input_current_limit_pin_o), .term_code_o(term_o), .prechg_code_o(pre_o),
    .term_pct_o(pct_o), .term_use_pct_o(use_pct), .floor_code_o(floor_o),
    .stat_o(st));
  ccs_host_model i_ccs_host_model (.clk_i(clk_i), .cfg_o(cfg_wdata_i),
    .write_o(host_write_i), .reset_bit_o(host_reset_bit_i),
    .read_o(fault_read_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic complete_run;
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [6:0] exp_term(input logic [6:0] t);
    return (t == 7'h00) ? 7'h01 : (t > 7'h4a) ? 7'h4a : t;
  endfunction
  task automatic wr_chk(input ccs_cfg_s w);
    i_ccs_host_model.pulse(0, w);
    cyc(2);
    chk("input_current_limit_pin", 8'(w.input_current_limit_pin_code), 8'(input_current_limit_pin_o));
    chk("term", 8'(exp_term(w.term_code)), 8'(term_o));
    chk("prechg", 8'(exp_term(w.term_code)), 8'(pre_o));
    chk("floor", 8'(w.floor_code), 8'(floor_o));
    chk("host", 8'h01, 8'(st.host_mode));
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hbea88d96));
    sense_i = '0;
    strap_i = '0;
    charge_disable_pin_i = 1'b0;
    sys_rst_i = 1'b1;
    cyc(3);
    sys_rst_i = 1'b0;
    cyc(1);
    chk("term_rst", 8'h14, 8'(term_o));
    chk("pct_rst", 8'h00, 8'(pct_o));
    chk("pct_unused", 8'h00, 8'(use_pct));
    chk("input_current_limit_pin_rst", 8'h00, 8'(input_current_limit_pin_o));
    strap_i = '{1'b1, 3'h5, 1'b1, 2'h3, 1'b1};
    sense_i.vin_valid = 1'b1;
    cyc(8);
    chk("input_current_limit_pin_ext", 8'h05, 8'(input_current_limit_pin_o));
    chk("pct_ext", 8'h03, 8'(pct_o));
    chk("use_pct", 8'h01, 8'(use_pct));
    for (int i = 0; i < 12; i++) begin
      c = ccs_cfg_s'(17'($urandom));
      if (i < 4) c.term_code = (i == 0) ? 7'h00 : 7'h4a + 7'(i - 1);
      wr_chk(c);
    end
    c = '0;
    c.floor_en = 1'b1;
    c.dbl_timer = 1'b1;
    c.term_en = 1'b1;
    wr_chk(c);
    sense_i.vin_at_floor = 1'b1;
    cyc(6);
    chk("floor_stat", 8'h01, 8'(st.floor_stat));
    chk("reduce", 8'h01, 8'(red_o));
    chk("timer", 8'h01, 8'(tmr_o));
    c.floor_en = 1'b0;
    wr_chk(c);
    cyc(4);
    chk("floor_off", 8'h00, 8'(st.floor_stat));
    chk("reduce_off", 8'h00, 8'(red_o));
    sense_i.in_cur_over_lim = 1'b1;
    cyc(6);
    chk("reduce_lim", 8'h01, 8'(red_o));
    sense_i = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    c.floor_en = 1'b1;
    c.chg_disable = 1'b1;
    wr_chk(c);
    cyc(6);
    chk("dis_bit", 8'h00, 8'(chg_on));
    chk("dis_path", 8'h00, 8'(dis_on));
    c.chg_disable = 1'b0;
    wr_chk(c);
    cyc(6);
    chk("cc", 8'h01, 8'(cc_o));
    chk("charging", 8'h01, 8'(st.progress));
    sense_i.cell_at_reg = 1'b1;
    sense_i.cur_below_taper = 1'b1;
    sense_i.cell_above_rechg = 1'b1;
    cyc(8);
    chk("cv", 8'h01, 8'(cv_o));
    chk("no_done_flr", 8'h01, 8'(st.progress));
    sense_i.mid_below_entry = 1'b1;
    cyc(6);
    sense_i.vin_at_floor = 1'b0;
    sense_i.mid_below_entry = 1'b0;
    cyc(8);
    chk("supp_hold", 8'h01, 8'(st.supplement));
    chk("no_done_sup", 8'h01, 8'(st.progress));
    sense_i.mid_above_exit = 1'b1;
    cyc(10);
    chk("supp_exit", 8'h00, 8'(st.supplement));
    chk("done", 8'h02, 8'(st.progress));
    chk("chg_off", 8'h00, 8'(chg_on));
    sense_i.cell_above_rechg = 1'b0;
    sense_i.cell_at_reg = 1'b0;
    charge_disable_pin_i = 1'b1;
    cyc(8);
    chk("pin_off", 8'h00, 8'(chg_on));
    charge_disable_pin_i = 1'b0;
    cyc(8);
    chk("pin_on", 8'h01, 8'(chg_on));
    sense_i.vin_ovp = 1'b1;
    cyc(3);
    sense_i.vin_ovp = 1'b0;
    cyc(8);
    chk("ovp_glitch", 8'h00, 8'(st.ovp_fault));
    for (int k = 0; k < 2; k++) begin
      if (k == 0) sense_i.vin_ovp = 1'b1;
      else sense_i.vin_uvlo = 1'b1;
      cyc(10);
      chk("alert_on", 8'h01, 8'(alert));
      cyc(10);
      chk("alert_off", 8'h00, 8'(alert));
      chk("fault", 8'h01, 8'(k ? st.uvlo_fault : st.ovp_fault));
      if (k == 0) chk("dis_ovp", 8'h01, 8'(dis_on));
      else chk("prog_flt", 8'h04, 8'(st.progress));
      i_ccs_host_model.pulse(2, c);
      cyc(3);
      chk("read_held", 8'h01, 8'(k ? st.uvlo_fault : st.ovp_fault));
      sense_i.vin_ovp = 1'b0;
      sense_i.vin_uvlo = 1'b0;
      cyc(8);
      chk("sticky", 8'h01, 8'(k ? st.uvlo_fault : st.ovp_fault));
      if (k == 0) chk("ovp_prog", 8'h00, 8'(st.progress == 3'h4));
      i_ccs_host_model.pulse(2, c);
      cyc(3);
      chk("cleared", 8'h00, 8'(k ? st.uvlo_fault : st.ovp_fault));
    end
    i_ccs_host_model.pulse(1, c);
    cyc(2);
    chk("rst_bit", 8'h00, 8'(st.host_mode));
    chk("input_current_limit_pin_dflt", 8'h05, 8'(input_current_limit_pin_o));
    wr_chk(c);
    sense_i.vin_valid = 1'b0;
    cyc(6);
    sense_i.vin_valid = 1'b1;
    cyc(8);
    chk("vin_dflt", 8'h00, 8'(st.host_mode));
    complete_run();
  end
endmodule
